// ==== verilog/dcf_top.sv ====
/*
 * dcf_top: comparator B and C value registers, address match logic and the
 * trace fifo read-out port of the debug unit, reached over apb.
 * Assumes the monitored cpu bus is on clk; trace words arrive from trace logic.
 */
// Summary of operation
// - power-on or ordinary reset clears comparator and fifo read-out registers to zero.
// - after end-run reset contents are undefined; any value is acceptable.
// - trace-ending reset with debug enabled, begin clear, keeps previous register values.
// - comparator B high bits set required level of address bits 15..8.
// - full mode ignores the comparator B high byte.
// - comparator B low bits set required level of address bits 7..0.
// - comparator C high bits set required level of address bits 15..8.
// - comparator C low bits set required level of address bits 7..0.
// - fifo high read-out returns bits 15..8 of current fifo word.
// - in event-only modes fifo high read-out returns 0x00.
// - fifo low read-out returns low byte; reading it advances to next entry.
// - in full mode comparator B matches data instead of an address.
`timescale 1ns/1ps
module dcf_top
   import dcf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic trace_end_rst,
   input wire logic debug_enable_bit,
   input wire logic begin_trace,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire dcf_bus_t cpu_bus,
   input wire logic trace_valid,
   output logic trace_ready,
   input wire dcf_word_t trace_word,
   output logic match_b,
   output logic match_c
);
   logic [7:0] cbh_q, cbh_d, cbl_q, cbl_d, cch_q, cch_d, ccl_q, ccl_d;
   logic full_q, full_d, evt_q, evt_d;
   logic [31:0] prdata_q, prdata_d;
   logic match_b_q, match_b_d, match_c_q, match_c_d;
   logic retain, wr_en, rd_en, low_pop;
   logic acc, rd_cap, done_q, done_d, arm_q, arm_d;
   logic [15:0] cmp_b_bits, cmp_c_bits, eq_b, eq_c;
   logic [15:0] idx;
   logic hit;
   logic fifo_valid;
   dcf_word_t fifo_word;

   // held-value reset: when a trace ends by reset with debug on and begin clear
   // retain qualify
   assign retain = trace_end_rst && debug_enable_bit && !begin_trace;

   // apb decode; one wait state so read data can leave from a flop:
   // the first access cycle loads prdata_q, the second completes the transfer
   assign idx = paddr[17:2];
   assign acc = psel && penable;
   assign pready = acc && done_q;
   assign wr_en = pready && pwrite;
   assign rd_en = pready && !pwrite;
   assign rd_cap = acc && !done_q && !pwrite;
   // handshake state; a low-byte read pops only if its answer came from a real entry,
   // so a word that lands between the two access cycles is not lost
   always_comb begin
      done_d = acc && !done_q;
      arm_d = arm_q;
      if (rd_cap) begin
         arm_d = fifo_valid;
      end
   end
   always_comb begin
      hit = (paddr[1:0] == 2'h0) && (paddr[31:18] == 14'h0) &&
            ((idx >= DCF_IDX_CBH && idx <= DCF_IDX_FL) || idx == DCF_IDX_CTRL || idx == DCF_IDX_STAT);
   end
   assign pslverr = pready && (!hit || (pwrite && (idx == DCF_IDX_FH || idx == DCF_IDX_FL ||
                    idx == DCF_IDX_STAT)));

   // reading the low byte pops the buffer, giving the next entry
   // pop on read
   assign low_pop = rd_en && hit && idx == DCF_IDX_FL && arm_q;

   dcf_buf2 #(.WIDTH(16)) dcf_buf2_inst (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(trace_valid),
      .in_ready(trace_ready),
      .in_data(trace_word),
      .out_valid(fifo_valid),
      .out_ready(low_pop),
      .out_data(fifo_word)
   );

   // register writes; only byte lane 0 carries the 8-bit values
   always_comb begin
      cbh_d = cbh_q;
      cbl_d = cbl_q;
      cch_d = cch_q;
      ccl_d = ccl_q;
      full_d = full_q;
      evt_d = evt_q;
      if (wr_en && hit && pstrb[0] && !retain) begin
         case (idx)
            DCF_IDX_CBH: cbh_d = pwdata[7:0];
            DCF_IDX_CBL: cbl_d = pwdata[7:0];
            DCF_IDX_CCH: cch_d = pwdata[7:0];
            DCF_IDX_CCL: ccl_d = pwdata[7:0];
            DCF_IDX_CTRL: begin
               full_d = pwdata[DCF_CTRL_FULL_BIT];
               evt_d = pwdata[DCF_CTRL_EVT_BIT];
            end
            default: ;
         endcase
      end
   end

   // read mux, registered into prdata; fifo reads show zero when empty
   always_comb begin
      prdata_d = prdata_q;
      if (rd_cap) begin
         prdata_d = 32'h0;
         case (idx)
            DCF_IDX_CBH: prdata_d[7:0] = cbh_q;
            DCF_IDX_CBL: prdata_d[7:0] = cbl_q;
            DCF_IDX_CCH: prdata_d[7:0] = cch_q;
            DCF_IDX_CCL: prdata_d[7:0] = ccl_q;
            DCF_IDX_FH: prdata_d[7:0] = (!fifo_valid || evt_q) ? DCF_EVT_HIGH : fifo_word.high;
            DCF_IDX_FL: prdata_d[7:0] = fifo_valid ? fifo_word.low : DCF_RST_BYTE;
            DCF_IDX_CTRL: begin
               prdata_d[DCF_CTRL_FULL_BIT] = full_q;
               prdata_d[DCF_CTRL_EVT_BIT] = evt_q;
            end
            DCF_IDX_STAT: begin
               prdata_d[DCF_STAT_VALID_BIT] = fifo_valid;
               prdata_d[DCF_STAT_MB_BIT] = match_b_q;
               prdata_d[DCF_STAT_MC_BIT] = match_c_q;
            end
            default: prdata_d = 32'h0;
         endcase
      end
   end
   // read data leaves from a flop, loaded in the first access cycle
   assign prdata = prdata_q;

   // per-bit compare: each stored bit gives the level its address bit must have
   assign cmp_b_bits = {cbh_q, cbl_q};
   assign cmp_c_bits = {cch_q, ccl_q};
   for (genvar i = 0; i < 16; i++) begin : g_bit_cmp
      assign eq_b[i] = (cpu_bus.addr[i] == cmp_b_bits[i]);
      assign eq_c[i] = (cpu_bus.addr[i] == cmp_c_bits[i]);
   end

   // comparators evaluate one bus cycle and register the result
   always_comb begin
      match_b_d = 1'b0;
      match_c_d = 1'b0;
      if (cpu_bus.valid) begin
         if (full_q) begin
            match_b_d = (cpu_bus.data == cbl_q);
         end else begin
            match_b_d = &eq_b;
         end
         match_c_d = &eq_c;
      end
   end
   assign match_b = match_b_q;
   assign match_c = match_c_q;

   // clear on reset; end-run reset on trace_end_rst leaves the values as they were, which is allowed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cbh_q <= DCF_RST_BYTE;
         cbl_q <= DCF_RST_BYTE;
         cch_q <= DCF_RST_BYTE;
         ccl_q <= DCF_RST_BYTE;
         full_q <= 1'b0;
         evt_q <= 1'b0;
         prdata_q <= 32'h0;
         match_b_q <= 1'b0;
         match_c_q <= 1'b0;
         done_q <= 1'b0;
         arm_q <= 1'b0;
      end else begin
         cbh_q <= cbh_d;
         cbl_q <= cbl_d;
         cch_q <= cch_d;
         ccl_q <= ccl_d;
         full_q <= full_d;
         evt_q <= evt_d;
         prdata_q <= prdata_d;
         match_b_q <= match_b_d;
         match_c_q <= match_c_d;
         done_q <= done_d;
         arm_q <= arm_d;
      end
   end

   // assertions
   property p_reset_clear;
      @(posedge clk) $rose(rst_n) |->
         (cbh_q == DCF_RST_BYTE && cbl_q == DCF_RST_BYTE && cch_q == DCF_RST_BYTE && ccl_q == DCF_RST_BYTE);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("registers not zero after reset");

   property p_retain;
      @(posedge clk) disable iff (!rst_n)
         retain |=> $stable(cbh_q) && $stable(cbl_q) && $stable(cch_q) && $stable(ccl_q);
   endproperty
   a_retain: assert property (p_retain) else $error("registers changed during retain");

   property p_match_b_addr;
      @(posedge clk) disable iff (!rst_n)
         (cpu_bus.valid && !full_q && cpu_bus.addr == {cbh_q, cbl_q}) |=> match_b_q;
   endproperty
   a_match_b_addr: assert property (p_match_b_addr) else $error("comparator B missed address");

   property p_match_b_miss;
      @(posedge clk) disable iff (!rst_n)
         (cpu_bus.valid && !full_q && cpu_bus.addr != {cbh_q, cbl_q}) |=> !match_b_q;
   endproperty
   a_match_b_miss: assert property (p_match_b_miss) else $error("comparator B false address match");

   property p_full_data;
      @(posedge clk) disable iff (!rst_n)
         (cpu_bus.valid && full_q) |=> (match_b_q == ($past(cpu_bus.data) == $past(cbl_q)));
   endproperty
   a_full_data: assert property (p_full_data) else $error("full mode data compare wrong");

   property p_match_c;
      @(posedge clk) disable iff (!rst_n)
         cpu_bus.valid |=> (match_c_q == ($past(cpu_bus.addr) == {$past(cch_q), $past(ccl_q)}));
   endproperty
   a_match_c: assert property (p_match_c) else $error("comparator C match wrong");

   property p_no_match_idle;
      @(posedge clk) disable iff (!rst_n) !cpu_bus.valid |=> !match_b_q && !match_c_q;
   endproperty
   a_no_match_idle: assert property (p_no_match_idle) else $error("match without a bus cycle");

   property p_cbl_write;
      @(posedge clk) disable iff (!rst_n)
         (wr_en && hit && pstrb[0] && !retain && idx == DCF_IDX_CBL) |=> cbl_q == $past(pwdata[7:0]);
   endproperty
   a_cbl_write: assert property (p_cbl_write) else $error("comparator B low write lost");

   property p_cch_write;
      @(posedge clk) disable iff (!rst_n)
         (wr_en && hit && pstrb[0] && !retain && idx == DCF_IDX_CCH) |=> cch_q == $past(pwdata[7:0]);
   endproperty
   a_cch_write: assert property (p_cch_write) else $error("comparator C high write lost");

   property p_ready_wait;
      @(posedge clk) disable iff (!rst_n) (psel && !penable) |=> !pready;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("ready before read data loaded");

   property p_evt_high;
      @(posedge clk) disable iff (!rst_n)
         (rd_cap && idx == DCF_IDX_FH && evt_q) |=> prdata[7:0] == DCF_EVT_HIGH;
   endproperty
   a_evt_high: assert property (p_evt_high) else $error("event-only high byte not zero");

   property p_high_byte;
      @(posedge clk) disable iff (!rst_n)
         (rd_cap && idx == DCF_IDX_FH && !evt_q && fifo_valid) |=> prdata[7:0] == $past(fifo_word.high);
   endproperty
   a_high_byte: assert property (p_high_byte) else $error("high byte wrong");

   property p_empty_fl_zero;
      @(posedge clk) disable iff (!rst_n)
         (rd_cap && idx == DCF_IDX_FL && !fifo_valid) |=> prdata == 32'h0;
   endproperty
   a_empty_fl_zero: assert property (p_empty_fl_zero) else $error("empty low byte read not zero");

   property p_fl_write_refused;
      @(posedge clk) disable iff (!rst_n) (pready && pwrite && idx == DCF_IDX_FL) |-> pslverr;
   endproperty
   a_fl_write_refused: assert property (p_fl_write_refused) else $error("low byte write accepted");

   property p_low_adv;
      @(posedge clk) disable iff (!rst_n)
         (low_pop && fifo_valid && !trace_valid) |=> !$stable(dcf_buf2_inst.rd_q);
   endproperty
   a_low_adv: assert property (p_low_adv) else $error("low read did not advance");

   c_match_b: cover property (@(posedge clk) disable iff (!rst_n) match_b_q);
   c_match_c: cover property (@(posedge clk) disable iff (!rst_n) match_c_q);
   c_pop: cover property (@(posedge clk) disable iff (!rst_n) low_pop && fifo_valid);
   c_full: cover property (@(posedge clk) disable iff (!rst_n) !trace_ready);
   c_retain_write: cover property (@(posedge clk) disable iff (!rst_n) retain && wr_en);
endmodule : dcf_top

// ==== verilog/dcf_pkg.sv ====
/*
 * dcf_pkg: constants and carrier types for the debug comparator B/C and
 * trace fifo read-out block. Assumes byte registers on a 32-bit apb bus.
 */
package dcf_pkg;
   // printed offsets are not word multiples: kept as indexes, byte address is 4x
   localparam logic [15:0] DCF_IDX_CBH = 16'h3012;
   localparam logic [15:0] DCF_IDX_CBL = 16'h3013;
   localparam logic [15:0] DCF_IDX_CCH = 16'h3014;
   localparam logic [15:0] DCF_IDX_CCL = 16'h3015;
   localparam logic [15:0] DCF_IDX_FH = 16'h3016;
   localparam logic [15:0] DCF_IDX_FL = 16'h3017;
   localparam logic [15:0] DCF_IDX_CTRL = 16'h3020;
   localparam logic [15:0] DCF_IDX_STAT = 16'h3021;
   localparam logic [7:0] DCF_RST_BYTE = 8'h00;
   localparam logic [7:0] DCF_EVT_HIGH = 8'h00;
   localparam int DCF_CTRL_FULL_BIT = 0;
   localparam int DCF_CTRL_EVT_BIT = 1;
   localparam int DCF_STAT_VALID_BIT = 0;
   localparam int DCF_STAT_MB_BIT = 1;
   localparam int DCF_STAT_MC_BIT = 2;

   // monitored cpu bus cycle
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic [7:0] data;
   } dcf_bus_t;

   // one trace word
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } dcf_word_t;
endpackage : dcf_pkg

// ==== verilog/dcf_buf2.sv ====
/*
 * dcf_buf2: two-entry valid/ready buffer of flip-flops.
 * Assumes one clock; contents clear only on rst_n, a trace-end reset leaves them.
 */
`timescale 1ns/1ps
module dcf_buf2 #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_q [2];
   logic [WIDTH-1:0] mem_d [2];
   logic rd_q, rd_d, wr_q, wr_d;
   logic [1:0] cnt_q, cnt_d;
   logic push, pop;

   // pointer and count update; out_data is not a flop but a mux of the two entry flops, selected by rd_q
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data;
         wr_d = ~wr_q;
      end
      if (pop) begin
         rd_d = ~rd_q;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 2'h1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 2'h1;
      end
   end

   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[rd_q];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         mem_q <= mem_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   property p_no_overflow;
      @(posedge clk) disable iff (!rst_n) cnt_q <= 2'h2;
   endproperty
   a_no_overflow: assert property (p_no_overflow) else $error("buffer count above two");
endmodule : dcf_buf2

// ==== verif/dcf_trace_src.sv ====
/*
 * dcf_trace_src: behavioural source of trace words for the fifo input.
 * Assumes one clock; push queues a word, words leave in order on valid/ready.
 */
`timescale 1ns/1ps
module dcf_trace_src
   import dcf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic push,
   input wire dcf_word_t push_word,
   output logic trace_valid,
   input wire logic trace_ready,
   output dcf_word_t trace_word
);
   dcf_word_t q[$];
   // word held until taken; idle lines show the inverse so stale data never passes
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q.delete();
         trace_valid <= 1'b0;
         trace_word <= 16'hFFFF;
      end else begin
         if (trace_valid && trace_ready) begin
            void'(q.pop_front());
         end
         if (push) begin
            q.push_back(push_word);
         end
         trace_valid <= (q.size() != 0);
         trace_word <= (q.size() != 0) ? q[0] : ~trace_word;
      end
   end
endmodule : dcf_trace_src

// ==== verif/dcf_top_tb.sv ====
/*
 * dcf_top_tb: self-checking bench for the comparator and fifo read-out block.
 * Assumes zero or more wait states on apb; a queue model feeds trace words.
 */
`timescale 1ns/1ps
module dcf_top_tb;
   import dcf_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic trace_end_rst = 1'b0, debug_enable_bit = 1'b0, begin_trace = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, push = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, trace_valid, trace_ready, match_b, match_c, err;
   dcf_bus_t cpu_bus = 25'h0;
   dcf_word_t trace_word, push_word = 16'h0;
   int n_mismatch = 0, samples_checked = 0;
   dcf_top dcf_top_inst (.clk, .rst_n, .trace_end_rst, .debug_enable_bit, .begin_trace, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .cpu_bus, .trace_valid, .trace_ready,
      .trace_word, .match_b, .match_c);
   dcf_trace_src dcf_trace_src_inst (.clk, .rst_n, .push, .push_word, .trace_valid, .trace_ready,
      .trace_word);
   // free-running 250 MHz clock
   always #2 clk = ~clk;
   task stop_test;
      if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one apb transfer; answer looked at mid-cycle, where it has settled, and the
   // request held through the rising edge at which pready stands high
   task apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
      logic rdy;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {14'h0, idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(negedge clk);
         rdy = pready;
         rd = prdata;
         err = pslverr;
      end while (rdy !== 1'b1);
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // one monitored bus cycle, match seen one cycle later
   task bus(input logic [15:0] a, input logic [7:0] d, input logic eb, input logic ec);
      @(posedge clk);
      cpu_bus <= {1'b1, a, d};
      @(posedge clk);
      cpu_bus <= {1'b0, ~a, ~d};
      #1;
      chk({30'h0, match_b, match_c}, {30'h0, eb, ec});
   endtask : bus
   task put(input logic [15:0] w);
      @(posedge clk);
      push <= 1'b1;
      push_word <= w;
      @(posedge clk);
      push <= 1'b0;
   endtask : put
   task t_reset;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, DCF_IDX_CBH + i[15:0], 8'h00);
         chk(rd, 32'h0);
      end
   endtask : t_reset
   task t_match;
      logic [7:0] v[4];
      v = '{8'h12, 8'h34, 8'hC3, 8'h5A};
      for (int i = 0; i < 4; i++) apb(1'b1, DCF_IDX_CBH + i[15:0], v[i]);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, DCF_IDX_CBH + i[15:0], 8'h00);
         chk(rd, {24'h0, v[i]});
      end
      bus(16'h1234, 8'h00, 1'b1, 1'b0);
      bus(16'hC35A, 8'h00, 1'b0, 1'b1);
      bus(16'h1334, 8'h00, 1'b0, 1'b0);
      bus(16'h1235, 8'h00, 1'b0, 1'b0);
      bus(16'hC25A, 8'h00, 1'b0, 1'b0);
      bus(16'hC35B, 8'h00, 1'b0, 1'b0);
   endtask : t_match
   task t_full;
      apb(1'b1, DCF_IDX_CTRL, 8'h01);
      apb(1'b0, DCF_IDX_CTRL, 8'h00);
      chk(rd, 32'h00000001 << DCF_CTRL_FULL_BIT);
      bus(16'hFF00, 8'h34, 1'b1, 1'b0);
      bus(16'h1234, 8'h35, 1'b0, 1'b0);
      apb(1'b1, DCF_IDX_CTRL, 8'h00);
   endtask : t_full
   // fill the buffer until it refuses, then drain in order
   task t_fifo;
      logic [15:0] w[3];
      w = '{16'h1234, 16'hABCD, 16'h5A6C};
      for (int i = 0; i < 3; i++) put(w[i]);
      repeat (4) @(posedge clk);
      #1;
      chk({31'h0, trace_ready}, 32'h0);
      apb(1'b0, DCF_IDX_STAT, 8'h00);
      chk(rd, 32'h00000001 << DCF_STAT_VALID_BIT);
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, DCF_IDX_FH, 8'h00);
         chk(rd, {24'h0, w[i][15:8]});
         apb(1'b0, DCF_IDX_FL, 8'h00);
         chk(rd, {24'h0, w[i][7:0]});
      end
      apb(1'b0, DCF_IDX_FL, 8'h00);
      chk(rd, 32'h0);
      apb(1'b0, DCF_IDX_STAT, 8'h00);
      chk(rd, 32'h0);
   endtask : t_fifo
   task t_event;
      apb(1'b1, DCF_IDX_CTRL, 8'h02);
      put(16'h77E1);
      put(16'h88F2);
      repeat (3) @(posedge clk);
      apb(1'b0, DCF_IDX_FH, 8'h00);
      chk(rd, {24'h0, DCF_EVT_HIGH});
      apb(1'b0, DCF_IDX_FL, 8'h00);
      chk(rd, 32'h000000E1);
      apb(1'b0, DCF_IDX_FL, 8'h00);
      chk(rd, 32'h000000F2);
      apb(1'b1, DCF_IDX_CTRL, 8'h00);
   endtask : t_event
   task t_err;
      apb(1'b0, 16'h3030, 8'h00);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, DCF_IDX_FL, 8'h77);
      chk({31'h0, err}, 32'h1);
   endtask : t_err
   // trace-ending reset keeps values, a real reset clears them
   task t_retain;
      @(posedge clk);
      trace_end_rst <= 1'b1;
      debug_enable_bit <= 1'b1;
      apb(1'b1, DCF_IDX_CBL, 8'h99);
      apb(1'b0, DCF_IDX_CBL, 8'h00);
      chk(rd, 32'h00000034);
      // with begin set the trace-end reset does not hold the values
      begin_trace <= 1'b1;
      apb(1'b1, DCF_IDX_CBL, 8'h56);
      apb(1'b0, DCF_IDX_CBL, 8'h00);
      chk(rd, 32'h00000056);
      trace_end_rst <= 1'b0;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, DCF_IDX_CBL, 8'h00);
      chk(rd, 32'h0);
   endtask : t_retain
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_match();
      t_full();
      t_fifo();
      t_event();
      t_err();
      t_retain();
      stop_test();
   end
   // watchdog well beyond the few hundred cycles the run needs
   initial begin
      #80000;
      n_mismatch++;
      stop_test();
   end
endmodule : dcf_top_tb
